// *** verilog/hpsl_host_port.sv ***
/*
  Host port, strap capture, general purpose pins and indicator pins of the controller.
  Assumes host pins synchronous to clk_in, a held synchronous reset, and ROM settings as static levels.
*/
// How it works
// - Command-type high selects the data port, low selects the index port.
// - Read strobe is active low unless the ROM setting makes it active high.
// - Write strobe is active low unless the ROM setting makes it active high.
// - Chip select is active low unless the ROM setting (16-bit mode) or the wake strap (8-bit mode) makes it active high.
// - Interrupt is active high; ROM setting or strap can make it active low.
// - Serial ROM clock strapped high makes the interrupt active low.
// - Serial ROM select strapped high picks the 8-bit bus, else 16-bit.
// - Upper data pins carry bits 8-15 in 16-bit mode, alternate pins otherwise.
// - In 8-bit mode pin 6 strapped high makes the interrupt open-drain, else actively driven.
// - In 8-bit mode pins 6-4 are outputs from the level register.
// - Pins 3-1 start as inputs; direction and level registers program them.
// - In 8-bit mode the wake pin follows detected wake-up events.
// - Duplex pin pulls low on full duplex or on 10 Mb/s, by LED mode.
// - Speed pin pulls low at 100 Mb/s, or acts as 16-bit cycle acknowledge.
// - Link pin shows link and carrier or carrier only, or wait or wake in 16-bit mode.
// - Packet memory is reached only by byte or word data-port command cycles.
// - Sixteen kilobytes of packet memory sit behind the data port.
// - Strap pins read one when pulled high and zero when floating.
// - In 8-bit mode the wake strap sets chip select polarity.
// - Host accesses are refused until 5 us after reset release.
`timescale 1ns/1ps
`include "hpsl_defines.svh"

module hpsl_host_port #(
  parameter int ADDR_W = `HPSL_MEM_ADDR_W,
  parameter int READY_W = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Host bus control
  input wire logic host_read_strobe_in,
  input wire logic host_write_strobe_in,
  input wire logic chip_select_in,
  input wire logic cmd_type_in,
  // Host data, low lane
  input wire logic [7:0] host_data_low_in,
  output logic [7:0] host_data_low_out,
  output logic host_data_low_oe_out,
  // Host data, high lane or alternate pins
  input wire logic [7:0] host_data_high_in,
  output logic [7:0] host_data_high_out,
  output logic [7:0] host_data_high_oe_out,
  // Strap pins
  input wire logic serial_rom_clock_in,
  input wire logic serial_rom_select_in,
  // Settings loaded from the configuration ROM
  input wire logic cfg_read_high_in,
  input wire logic cfg_write_high_in,
  input wire logic cfg_cs_high_in,
  input wire logic cfg_int_low_in,
  input wire logic cfg_led_mode_in,
  input wire logic cfg_speed_isa_width_ack_in,
  input wire hpsl_pkg::hpsl_link_fn_e cfg_link_fn_in,
  // Internal events and PHY status
  input wire logic irq_event_in,
  input wire logic wake_event_in,
  input wire logic phy_speed100_in,
  input wire logic phy_full_duplex_in,
  input wire logic phy_link_in,
  input wire logic phy_carrier_in,
  // Interrupt pin
  output logic int_out,
  output logic int_oe_out,
  // Indicator pins
  output logic speed_indicator_out,
  output logic speed_indicator_oe_out,
  output logic link_activity_indicator_out,
  output logic link_activity_indicator_oe_out,
  // Status
  output logic host_ready_out,
  output logic bus8_mode_out
);

  import hpsl_pkg::*;

  localparam logic [READY_W-1:0] READY_CNT = READY_W'(`HPSL_READY_CYCLES);

  function automatic logic pin_active(input logic level, input logic high_active);
    return high_active ? level : !level;
  endfunction

  hpsl_cyc_e state;
  logic rst_q;
  logic straps_done;
  logic strap_int_low;
  logic strap_bus8;
  logic strap_cs_high;
  logic strap_od;
  logic [READY_W-1:0] boot_cnt;
  logic ready;
  logic rd_act;
  logic wr_act;
  logic cs_act;
  logic rd_req;
  logic wr_req;
  logic rd_start;
  logic wr_start;
  logic rd_cyc;
  logic rd_data_port;
  logic rd_drive;
  logic [7:0] index;
  logic [7:0] gp_dir;
  logic [7:0] gp_level;
  logic [7:0] gp_view;
  logic [ADDR_W-1:0] mem_waddr;
  logic [ADDR_W-1:0] mem_raddr;
  logic [ADDR_W-1:0] addr_step;
  logic [7:0] mem_rd_lo;
  logic [7:0] mem_rd_hi;
  logic mem_wr_en;
  logic [7:0] read_value;
  logic [7:0] rd_lo;
  logic [7:0] rd_hi;
  logic int_pol_low;
  logic int_level;
  logic duplex_on;
  logic link_on;
  logic isa_width_ack_on;

  // Strap capture on the first edge after reset release; pins are not driven yet
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rst_q <= 1'b1;
    end
    else
    begin
      rst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      straps_done <= 1'b0;
      strap_int_low <= 1'b0;
      strap_bus8 <= 1'b0;
      strap_cs_high <= 1'b0;
      strap_od <= 1'b0;
    end
    else if (rst_q)
    begin
      straps_done <= 1'b1;
      strap_int_low <= serial_rom_clock_in;
      strap_bus8 <= serial_rom_select_in;
      strap_cs_high <= host_data_high_in[`HPSL_HI_WAKE];
      strap_od <= host_data_high_in[`HPSL_HI_GP6];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      boot_cnt <= '0;
    end
    else if (straps_done && boot_cnt != READY_CNT)
    begin
      boot_cnt <= READY_W'(boot_cnt + 1'b1);
    end
  end

  assign ready = (boot_cnt == READY_CNT);

  // Strobe decode
  assign rd_act = pin_active(host_read_strobe_in, cfg_read_high_in);
  assign wr_act = pin_active(host_write_strobe_in, cfg_write_high_in);
  assign cs_act = pin_active(chip_select_in, strap_bus8 ? strap_cs_high : cfg_cs_high_in);
  assign rd_req = ready && cs_act && rd_act;
  assign wr_req = ready && cs_act && wr_act;
  // One access per strobe; a read wins if both strobes appear together
  assign rd_start = (state == HPSL_IDLE) && rd_req;
  assign wr_start = (state == HPSL_IDLE) && wr_req && !rd_req;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= HPSL_BOOT;
    end
    else
    begin
      unique case (state)
        HPSL_BOOT:
        begin
          if (ready)
          begin
            state <= HPSL_IDLE;
          end
        end
        HPSL_IDLE:
        begin
          if (rd_start || wr_start)
          begin
            state <= HPSL_BUSY;
          end
        end
        HPSL_BUSY:
        begin
          if (!rd_req && !wr_req)
          begin
            state <= HPSL_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rd_cyc <= 1'b0;
      rd_data_port <= 1'b0;
    end
    else if (rd_start || wr_start)
    begin
      rd_cyc <= rd_start;
      rd_data_port <= cmd_type_in;
    end
  end

  // Index latch
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      index <= 8'h00;
    end
    else if (wr_start && !cmd_type_in)
    begin
      index <= host_data_low_in;
    end
  end

  // General purpose registers
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      gp_dir <= `HPSL_RST_GP_DIR;
      gp_level <= `HPSL_RST_GP_LEVEL;
    end
    else if (wr_start && cmd_type_in)
    begin
      if (index == `HPSL_OFS_GP_DIR)
      begin
        gp_dir <= host_data_low_in;
      end
      if (index == `HPSL_OFS_GP_LEVEL)
      begin
        gp_level <= host_data_low_in;
      end
    end
  end

  // Input pins read their pin level, output pins read back the register
  always_comb
  begin
    gp_view = gp_level;
    for (int i = `HPSL_GP_BI_LSB; i <= `HPSL_GP_BI_MSB; i++)
    begin
      if (!gp_dir[i])
      begin
        gp_view[i] = host_data_high_in[i-1];
      end
    end
  end

  // Packet memory pointers, advanced one byte or one word per command cycle
  assign addr_step = strap_bus8 ? ADDR_W'(1) : ADDR_W'(2);
  assign mem_wr_en = wr_start && cmd_type_in && (index == `HPSL_OFS_MEM_WR_INC);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mem_waddr <= '0;
    end
    else if (wr_start && cmd_type_in)
    begin
      if (index == `HPSL_OFS_MEM_WR_LO)
      begin
        mem_waddr[7:0] <= host_data_low_in;
      end
      else if (index == `HPSL_OFS_MEM_WR_HI)
      begin
        mem_waddr[ADDR_W-1:8] <= host_data_low_in[ADDR_W-9:0];
      end
      else if (index == `HPSL_OFS_MEM_WR_INC)
      begin
        mem_waddr <= ADDR_W'(mem_waddr + addr_step);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mem_raddr <= '0;
    end
    else if (cmd_type_in && (wr_start || rd_start))
    begin
      if (wr_start && index == `HPSL_OFS_MEM_RD_LO)
      begin
        mem_raddr[7:0] <= host_data_low_in;
      end
      else if (wr_start && index == `HPSL_OFS_MEM_RD_HI)
      begin
        mem_raddr[ADDR_W-1:8] <= host_data_low_in[ADDR_W-9:0];
      end
      else if (rd_start && index == `HPSL_OFS_MEM_RD_INC)
      begin
        mem_raddr <= ADDR_W'(mem_raddr + addr_step);
      end
    end
  end

  hpsl_packet_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk_in(clk_in),
    .wr_en_in(mem_wr_en),
    .wr_wide_in(!strap_bus8),
    .wr_addr_in(mem_waddr),
    .wr_lo_in(host_data_low_in),
    .wr_hi_in(host_data_high_in),
    .rd_addr_in(mem_raddr),
    .rd_lo_out(mem_rd_lo),
    .rd_hi_out(mem_rd_hi)
  );

  // Read data; unmapped offsets read zero
  always_comb
  begin
    read_value = 8'h00;
    if (!cmd_type_in)
    begin
      read_value = index;
    end
    else
    begin
      case (index)
        `HPSL_OFS_GP_DIR: read_value = gp_dir;
        `HPSL_OFS_GP_LEVEL: read_value = gp_view;
        `HPSL_OFS_MEM_RD_INC: read_value = mem_rd_lo;
        `HPSL_OFS_MEM_RD_LO: read_value = mem_raddr[7:0];
        `HPSL_OFS_MEM_RD_HI: read_value = 8'(mem_raddr[ADDR_W-1:8]);
        `HPSL_OFS_MEM_WR_LO: read_value = mem_waddr[7:0];
        `HPSL_OFS_MEM_WR_HI: read_value = 8'(mem_waddr[ADDR_W-1:8]);
        default: read_value = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rd_lo <= 8'h00;
      rd_hi <= 8'h00;
    end
    else if (rd_start)
    begin
      rd_lo <= read_value;
      rd_hi <= (cmd_type_in && index == `HPSL_OFS_MEM_RD_INC) ? mem_rd_hi : 8'h00;
    end
  end

  // Data is driven only while the read strobe is still held
  assign rd_drive = (state == HPSL_BUSY) && rd_cyc && rd_req;
  assign host_data_low_out = rd_lo;
  assign host_data_low_oe_out = rd_drive;

  // Upper pins: data lane in 16-bit mode, wake, duplex and general pins in 8-bit mode
  assign duplex_on = cfg_led_mode_in ? phy_full_duplex_in : !phy_speed100_in;
  assign host_data_high_out = strap_bus8 ?
    {wake_event_in, 1'b0, gp_level[`HPSL_GP_UP_MSB:`HPSL_GP_BI_LSB]} : rd_hi;
  assign host_data_high_oe_out = !straps_done ? 8'h00 :
    strap_bus8 ? {1'b1, duplex_on, 3'b111, gp_dir[`HPSL_GP_BI_MSB:`HPSL_GP_BI_LSB]} :
    {8{rd_drive && rd_data_port}};

  // Interrupt pin; open-drain can only pull low, so it releases to show the high level
  assign int_pol_low = strap_int_low || cfg_int_low_in;
  assign int_level = (ready && irq_event_in) ^ int_pol_low;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      int_out <= 1'b0;
      int_oe_out <= 1'b1;
    end
    else if (strap_bus8 && strap_od)
    begin
      int_out <= 1'b0;
      int_oe_out <= !int_level;
    end
    else
    begin
      int_out <= int_level;
      int_oe_out <= 1'b1;
    end
  end

  // Indicator pins pull low when lit and float otherwise; in 16-bit mode the link pin drives its level in wait or wake function
  assign isa_width_ack_on = ready && cs_act && cmd_type_in;
  assign speed_indicator_out = 1'b0;
  assign speed_indicator_oe_out = (!strap_bus8 && cfg_speed_isa_width_ack_in) ? isa_width_ack_on : phy_speed100_in;

  assign link_on = cfg_led_mode_in ? (phy_link_in || phy_carrier_in) : phy_carrier_in;

  // Every access completes in one cycle, so the wait function never holds the host
  always_comb
  begin
    link_activity_indicator_out = 1'b0;
    link_activity_indicator_oe_out = link_on;
    if (!strap_bus8 && cfg_link_fn_in == HPSL_LINK_WAIT)
    begin
      link_activity_indicator_out = 1'b1;
      link_activity_indicator_oe_out = 1'b1;
    end
    else if (!strap_bus8 && cfg_link_fn_in == HPSL_LINK_WAKE)
    begin
      link_activity_indicator_out = wake_event_in;
      link_activity_indicator_oe_out = 1'b1;
    end
  end

  assign host_ready_out = ready;
  assign bus8_mode_out = strap_bus8;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence seq_index_write;
    wr_start && !cmd_type_in;
  endsequence

  sequence seq_incr_write;
    wr_start && cmd_type_in && index == `HPSL_OFS_MEM_WR_INC;
  endsequence

  a_no_early_access: assert property (!ready |-> state == HPSL_BOOT && !host_data_low_oe_out)
    else $error("host access taken before ready");
  a_boot_hold: assert property ($rose(straps_done) |-> !ready [*8])
    else $error("ready too soon after reset release");
  a_ready_count: assert property ($rose(ready) |-> $past(boot_cnt) == READY_W'(READY_CNT - 1'b1))
    else $error("ready count wrong");
  a_index_latch: assert property (seq_index_write |=> index == $past(host_data_low_in))
    else $error("index not latched");
  a_data_keeps_index: assert property (wr_start && cmd_type_in |=> $stable(index))
    else $error("data write moved index");
  a_mem_step: assert property (seq_incr_write ##1 1'b1 |-> mem_waddr == ADDR_W'($past(mem_waddr) + $past(addr_step)))
    else $error("write pointer step wrong");
  a_gp_reset_dir: assert property ($fell(rst_q) |-> gp_dir == `HPSL_RST_GP_DIR)
    else $error("general pins not inputs after reset");
  a_gp_upper_out: assert property (strap_bus8 && straps_done |-> host_data_high_oe_out[5:3] == 3'b111
    && host_data_high_out[5:3] == gp_level[6:4])
    else $error("upper general pins not driven");
  a_wake_pin: assert property (strap_bus8 && straps_done |-> host_data_high_out[7] == wake_event_in)
    else $error("wake pin wrong");
  a_int_level: assert property (!(strap_bus8 && strap_od) ##1 !(strap_bus8 && strap_od) |->
    int_out == ($past(ready && irq_event_in) ^ $past(int_pol_low)))
    else $error("interrupt level wrong");
  a_int_od: assert property (strap_bus8 && strap_od |=> !int_out)
    else $error("open-drain interrupt driven high");
  a_read_drive: assert property (rd_start |=> rd_req |-> host_data_low_oe_out)
    else $error("read data not driven");
  a_speed_led: assert property (strap_bus8 |-> speed_indicator_oe_out == phy_speed100_in)
    else $error("speed indicator wrong");

endmodule

// *** verilog/hpsl_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts of the host port block.
  Included by the host port and packet memory design files; holds definitions only.
*/
`ifndef HPSL_DEFINES_SVH
`define HPSL_DEFINES_SVH

`define HPSL_CLK_MHZ 25
`define HPSL_READY_NS 5000
`define HPSL_READY_CYCLES ((`HPSL_READY_NS * `HPSL_CLK_MHZ + 999) / 1000)

`define HPSL_OFS_GP_DIR 8'h1e
`define HPSL_OFS_GP_LEVEL 8'h1f
`define HPSL_OFS_MEM_RD_INC 8'hf2
`define HPSL_OFS_MEM_RD_LO 8'hf4
`define HPSL_OFS_MEM_RD_HI 8'hf5
`define HPSL_OFS_MEM_WR_INC 8'hf8
`define HPSL_OFS_MEM_WR_LO 8'hfa
`define HPSL_OFS_MEM_WR_HI 8'hfb

`define HPSL_RST_GP_DIR 8'h01
`define HPSL_RST_GP_LEVEL 8'h00

`define HPSL_GP_UP_MSB 6
`define HPSL_GP_UP_LSB 4
`define HPSL_GP_BI_MSB 3
`define HPSL_GP_BI_LSB 1

`define HPSL_HI_GP6 5
`define HPSL_HI_DUPLEX 6
`define HPSL_HI_WAKE 7

`define HPSL_MEM_ADDR_W 14

`endif

// *** verilog/hpsl_pkg.sv ***
/*
  Types shared by the host port block: access cycle states and link pin functions.
  Assumes nothing of its surroundings.
*/
package hpsl_pkg;

  typedef enum logic [1:0] {HPSL_BOOT, HPSL_IDLE, HPSL_BUSY} hpsl_cyc_e;

  typedef enum logic [1:0] {HPSL_LINK_LED, HPSL_LINK_WAIT, HPSL_LINK_WAKE} hpsl_link_fn_e;

endpackage

// *** verilog/hpsl_packet_mem.sv ***
/*
  Packet buffer of the host port block: byte array, one or two bytes per access.
  Assumes a single clock; reads are combinational, the caller registers them.
*/
`timescale 1ns/1ps
`include "hpsl_defines.svh"

module hpsl_packet_mem #(
  parameter int ADDR_W = `HPSL_MEM_ADDR_W
) (
  // Clock
  input wire logic clk_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic wr_wide_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_lo_in,
  input wire logic [7:0] wr_hi_in,
  // Read side
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0] rd_lo_out,
  output logic [7:0] rd_hi_out
);

  logic [7:0] mem [0:(2**ADDR_W)-1];
  logic [ADDR_W-1:0] wr_addr_next;
  logic [ADDR_W-1:0] rd_addr_next;

  assign wr_addr_next = ADDR_W'(wr_addr_in + 1'b1);
  assign rd_addr_next = ADDR_W'(rd_addr_in + 1'b1);

  // No reset: buffer contents are undefined until written
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_lo_in;
      if (wr_wide_in)
      begin
        mem[wr_addr_next] <= wr_hi_in;
      end
    end
  end

  assign rd_lo_out = mem[rd_addr_in];
  assign rd_hi_out = mem[rd_addr_next];

endmodule

// *** verif/hpsl_host_model.sv ***
/*
  Behavioural host processor for the host port: one task runs a full index or data cycle.
  Assumes the bench resolves the data lanes and drives straps; the strobe and select
  polarities are given to it as levels that match the device settings.
*/
`timescale 1ns/1ps

module hpsl_host_model (
  // Clock
  input wire logic clk_in,
  // Polarity the device expects
  input wire logic rd_high_in,
  input wire logic wr_high_in,
  input wire logic cs_high_in,
  // Resolved data lanes
  input wire logic [7:0] data_low_in,
  input wire logic [7:0] data_high_in,
  // Bus pins driven by the host
  output logic read_strobe_out,
  output logic write_strobe_out,
  output logic select_out,
  output logic cmd_type_out,
  output logic [7:0] drive_low_out,
  output logic [7:0] drive_high_out,
  output logic drive_en_out
);
  logic rd_act = 1'b0;
  logic wr_act = 1'b0;
  logic sel_act = 1'b0;

  assign read_strobe_out = ~(rd_act ^ rd_high_in);
  assign write_strobe_out = ~(wr_act ^ wr_high_in);
  assign select_out = ~(sel_act ^ cs_high_in);

  initial
  begin
    cmd_type_out = 1'b0;
    drive_low_out = 8'h00;
    drive_high_out = 8'h00;
    drive_en_out = 1'b0;
  end

  // Request held for start edge and answer edge, then a full idle cycle
  task automatic access(input logic wr, input logic cmd, input logic [15:0] wdata, output logic [15:0] rdata);
    @(negedge clk_in);
    cmd_type_out = cmd;
    {drive_high_out, drive_low_out} = wdata;
    drive_en_out = wr;
    sel_act = 1'b1;
    rd_act = ~wr;
    wr_act = wr;
    repeat (2) @(negedge clk_in);
    rdata = {data_high_in, data_low_in};
    rd_act = 1'b0;
    wr_act = 1'b0;
    sel_act = 1'b0;
    drive_en_out = 1'b0;
    // Released data no longer shows the last value
    {drive_high_out, drive_low_out} = ~wdata;
  endtask
endmodule

// *** verif/host_port_strap_led_logic_bench.sv ***
/*
  Self-checking bench of the host port: 16-bit run, then an 8-bit run with straps and inverted polarities.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps

module host_port_strap_led_logic_bench;
  import hpsl_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic rd_high = 1'b0, wr_high = 1'b0, cs_high = 1'b0, int_low = 1'b0, led_mode = 1'b0, isa_width_ack = 1'b0;
  logic rclk = 1'b0, rsel = 1'b0, irq = 1'b0, wake = 1'b0;
  logic spd = 1'b0, fdx = 1'b0, lnk = 1'b0, crs = 1'b0, mode8 = 1'b0, host_cs_high = 1'b0;
  hpsl_link_fn_e link_fn = HPSL_LINK_LED;
  logic [7:0] pull = 8'h00;
  logic h_rd, h_wr, h_cs, h_cmd, h_en, lo_oe, int_o, int_oe, spd_o, spd_oe, lnk_o, lnk_oe, ready, bus8;
  logic [7:0] h_lo, h_hi, lo_in, lo_out, hi_in, hi_out, hi_oe;
  logic [15:0] d;
  int bad_count = 0;
  int comparisons = 0;

  always #20 clk_in = ~clk_in;

  // Pull-downs hold undriven pins low unless strapped high
  assign lo_in = lo_oe ? lo_out : (h_en ? h_lo : 8'h00);
  assign hi_in = (hi_oe & hi_out) | (~hi_oe & ((h_en && !mode8) ? h_hi : pull));

  hpsl_host_port hpsl_host_port_i (
    .clk_in(clk_in), .srst_in(srst_in), .host_read_strobe_in(h_rd), .host_write_strobe_in(h_wr),
    .chip_select_in(h_cs), .cmd_type_in(h_cmd), .host_data_low_in(lo_in), .host_data_low_out(lo_out),
    .host_data_low_oe_out(lo_oe), .host_data_high_in(hi_in), .host_data_high_out(hi_out),
    .host_data_high_oe_out(hi_oe), .serial_rom_clock_in(rclk), .serial_rom_select_in(rsel),
    .cfg_read_high_in(rd_high), .cfg_write_high_in(wr_high), .cfg_cs_high_in(cs_high),
    .cfg_int_low_in(int_low), .cfg_led_mode_in(led_mode), .cfg_speed_isa_width_ack_in(isa_width_ack),
    .cfg_link_fn_in(link_fn), .irq_event_in(irq), .wake_event_in(wake), .phy_speed100_in(spd),
    .phy_full_duplex_in(fdx), .phy_link_in(lnk), .phy_carrier_in(crs), .int_out(int_o),
    .int_oe_out(int_oe), .speed_indicator_out(spd_o), .speed_indicator_oe_out(spd_oe),
    .link_activity_indicator_out(lnk_o), .link_activity_indicator_oe_out(lnk_oe),
    .host_ready_out(ready), .bus8_mode_out(bus8));

  hpsl_host_model hpsl_host_model_i (
    .clk_in(clk_in), .rd_high_in(rd_high), .wr_high_in(wr_high), .cs_high_in(host_cs_high),
    .data_low_in(lo_in), .data_high_in(hi_in), .read_strobe_out(h_rd), .write_strobe_out(h_wr),
    .select_out(h_cs), .cmd_type_out(h_cmd), .drive_low_out(h_lo), .drive_high_out(h_hi),
    .drive_en_out(h_en));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Host waits for the device to report ready before any access
  task automatic do_reset();
    int n;
    srst_in = 1'b1;
    tick(12);
    srst_in = 1'b0;
    n = 0;
    repeat (120)
    begin
      @(negedge clk_in);
      if (ready !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    n = 0;
    while (ready !== 1'b1 && n < 20)
    begin
      @(negedge clk_in);
      n++;
    end
    check(16'(ready), 16'h0001);
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [15:0] val);
    logic [15:0] x;
    hpsl_host_model_i.access(1'b1, 1'b0, {8'h00, ofs}, x);
    hpsl_host_model_i.access(1'b1, 1'b1, val, x);
  endtask

  task automatic rd_reg(input logic [7:0] ofs, output logic [15:0] val);
    logic [15:0] x;
    hpsl_host_model_i.access(1'b1, 1'b0, {8'h00, ofs}, x);
    hpsl_host_model_i.access(1'b0, 1'b1, 16'h0000, val);
  endtask

  initial
  begin
    tick(40000);
    bad_count++;
    end_sim();
  end

  initial
  begin
    do_reset();
    check(16'(bus8), 16'h0000);
    irq = 1'b1;
    tick(3);
    check(16'({int_oe, int_o}), 16'h0003);
    int_low = 1'b1;
    tick(3);
    check(16'({int_oe, int_o}), 16'h0002);
    int_low = 1'b0;
    // Both sides switch to an active-high select for one register read
    cs_high = 1'b1;
    host_cs_high = 1'b1;
    rd_reg(8'h1e, d);
    check(d, 16'h0001);
    cs_high = 1'b0;
    host_cs_high = 1'b0;
    rd_reg(8'h1e, d);
    check(d, 16'h0001);
    hpsl_host_model_i.access(1'b0, 1'b0, 16'h0000, d);
    check(d, 16'h001e);
    wr_reg(8'hfa, 16'h00fe);
    wr_reg(8'hfb, 16'h003f);
    wr_reg(8'hf8, 16'hbeef);
    wr_reg(8'hfa, 16'h0000);
    wr_reg(8'hfb, 16'h0000);
    wr_reg(8'hf8, 16'h1234);
    wr_reg(8'hf4, 16'h00fe);
    wr_reg(8'hf5, 16'h003f);
    rd_reg(8'hf2, d);
    check(d, 16'hbeef);
    hpsl_host_model_i.access(1'b0, 1'b1, 16'h0000, d);
    check(d, 16'h1234);
    spd = 1'b1;
    tick(1);
    check(16'({spd_oe, spd_o}), 16'h0002);
    // Acknowledge function: no selected data cycle, so the pin floats
    isa_width_ack = 1'b1;
    tick(1);
    check(16'(spd_oe), 16'h0000);
    isa_width_ack = 1'b0;
    spd = 1'b0;
    crs = 1'b1;
    tick(1);
    check(16'({spd_oe, lnk_oe}), 16'h0001);
    led_mode = 1'b1;
    crs = 1'b0;
    lnk = 1'b1;
    tick(1);
    check(16'(lnk_oe), 16'h0001);
    led_mode = 1'b0;
    tick(1);
    check(16'(lnk_oe), 16'h0000);
    link_fn = HPSL_LINK_WAIT;
    tick(1);
    check(16'({lnk_oe, lnk_o}), 16'h0003);
    link_fn = HPSL_LINK_WAKE;
    wake = 1'b1;
    tick(1);
    check(16'({lnk_oe, lnk_o}), 16'h0003);
    // Second run: 8-bit straps, open-drain interrupt, active-high strobes and select
    irq = 1'b0;
    wake = 1'b0;
    rd_high = 1'b1;
    wr_high = 1'b1;
    rclk = 1'b1;
    rsel = 1'b1;
    mode8 = 1'b1;
    pull = 8'ha5;
    host_cs_high = 1'b1;
    do_reset();
    check(16'(bus8), 16'h0001);
    check(16'(int_oe), 16'h0000);
    irq = 1'b1;
    tick(3);
    check(16'({int_oe, int_o}), 16'h0002);
    host_cs_high = 1'b0;
    wr_reg(8'h1e, 16'h00ff);
    host_cs_high = 1'b1;
    rd_reg(8'h1e, d);
    check(d[7:0], 16'h0001);
    rd_reg(8'h1f, d);
    check(d[7:0] & 8'h0e, 16'h000a);
    wr_reg(8'h1e, 16'h0003);
    wr_reg(8'h1f, 16'h0072);
    tick(1);
    check(16'({hi_oe[5:3], hi_out[5:3]}), 16'h003f);
    check(16'({hi_oe[0], hi_out[0]}), 16'h0003);
    wake = 1'b1;
    tick(1);
    check(16'({hi_oe[7], hi_out[7]}), 16'h0003);
    led_mode = 1'b1;
    fdx = 1'b1;
    tick(1);
    check(16'({hi_oe[6], hi_out[6]}), 16'h0002);
    fdx = 1'b0;
    tick(1);
    check(16'(hi_oe[6]), 16'h0000);
    led_mode = 1'b0;
    tick(1);
    check(16'(hi_oe[6]), 16'h0001);
    wr_reg(8'hfa, 16'h0000);
    wr_reg(8'hfb, 16'h0000);
    wr_reg(8'hf8, 16'h00a5);
    hpsl_host_model_i.access(1'b1, 1'b1, 16'h005a, d);
    wr_reg(8'hf4, 16'h0000);
    wr_reg(8'hf5, 16'h0000);
    rd_reg(8'hf2, d);
    check(d[7:0], 16'h00a5);
    hpsl_host_model_i.access(1'b0, 1'b1, 16'h0000, d);
    check(d[7:0], 16'h005a);
    end_sim();
  end
endmodule
